// ==== adc_link_pkg.sv ====
// Shared constants and types for the serial converter link and its controller
`default_nettype none
package adc_link_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int REF_UP_NS = 65000;
    localparam int REF_UP_CYC = (REF_UP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF = 4;
    localparam int CONV_CYC = 16;
    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] CONV_BITS = 8'h10;
    localparam logic [7:0] TEMP_BITS = 8'hC0;
    localparam logic [7:0] CONV_ZERO_BYTES = 8'h02;
    localparam logic [7:0] TEMP_ZERO_BYTES = 8'h18;
    localparam logic [4:0] ENTRY_BITS = 5'h10;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [1:0] CKM_EXT = 2'h3;
    localparam logic [7:0] SETUP_RST = 8'h60;
    // ------------------------------------------------------------
    // Controller register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_GO = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    localparam int CTRL_WAIT_EOC = 16;
    localparam int CTRL_REF_HOLD = 17;
    localparam int INT_DONE = 0;
    localparam int INT_EOC = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        H_IDLE,
        H_WAIT_EOC,
        H_SHIFT,
        H_HOLD
    } host_state_t;
endpackage
`default_nettype wire

// ==== adc_link_if.sv ====
// Serial link between converter and its controller
`default_nettype none
interface adc_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic eoc_n;
    modport device (
        input cs_n,
        input sclk,
        input mosi,
        output miso,
        output eoc_n
    );
    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input miso,
        input eoc_n
    );
endinterface
`default_nettype wire

// ==== adc_serial_device.sv ====
// Converter end of the serial link: command decode, externally clocked conversion, FIFO readout
`default_nettype none
// Behaviour
// - mode 11 conversion byte starts single clocked conversion
// - mode 11 ignores scan, averaging; streams result
// - host sends conversion byte plus 16 clocks
// - chip-select pulse after byte under 100us
// - back-to-back: one zero byte between conversions
// - host holds select high 65us for reference
// - temperature: 24 zero bytes after conversion byte
// - temperature appears in final two bytes
// - short first byte: next read continues eight bits
// - short second byte discards rest of entry
// - other entries survive; ignore four leading bits
// - partial write updates bits from MSB down
// - select before end-of-conversion corrupts the FIFO
// - straight binary conversion code
// - temperature code, one LSB 0.125 degrees
// - finished internal conversion drives end-of-conversion low
module adc_serial_device #(
    parameter int DEPTH = adc_link_pkg::FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    adc_link_if.device link,
    input wire logic [9:0] adc_code,
    input wire logic [11:0] temp_code,
    output logic conv_start,
    output logic [3:0] conv_channel,
    output logic [1:0] clock_mode
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic sclk_m;
        logic sclk_s;
        logic sclk_d;
        logic cs_m;
        logic cs_s;
        logic cs_d;
        logic mosi_m;
        logic mosi_s;
        logic [7:0] rx_sh;
        logic [2:0] rx_cnt;
        logic [7:0] setup;
        logic [7:0] avg;
        logic [7:0] conv;
        logic [7:0] ext_cnt;
        logic [15:0] ext_frame;
        logic ext_arm;
        logic ext_temp;
        logic [DEPTH-1:0][15:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic [4:0] pos;
        logic [4:0] stop;
        logic busy;
        logic [7:0] busy_cnt;
        logic eoc_n;
        logic miso;
        logic start;
        logic [3:0] chan;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;
    logic rise;
    logic fall_raw;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic fifo_empty;
    logic [7:0] byte_in;
    logic [2:0] sh_amt;
    logic [7:0] wmask;
    logic [7:0] wbits;
    logic [AW:0] wp;
    logic [15:0] adc_entry;
    logic [15:0] temp_entry;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.sclk_m = link.sclk;
        next_s.sclk_s = s.sclk_m;
        next_s.sclk_d = s.sclk_s;
        next_s.cs_m = link.cs_n;
        next_s.cs_s = s.cs_m;
        next_s.cs_d = s.cs_s;
        next_s.mosi_m = link.mosi;
        next_s.mosi_s = s.mosi_m;
        rise = s.sclk_s & ~s.sclk_d & ~s.cs_s;
        // Clocked result keeps shifting across a select pulse after the command byte
        fall_raw = ~s.sclk_s & s.sclk_d;
        fall = fall_raw & ~s.cs_s;
        cs_fall = ~s.cs_s & s.cs_d;
        cs_rise = s.cs_s & ~s.cs_d;
        fifo_empty = (s.wr_ptr == s.rd_ptr);
        byte_in = {s.rx_sh[6:0], s.mosi_s};
        sh_amt = 3'(4'h8 - {1'b0, s.rx_cnt});
        wmask = 8'hFF << sh_amt;
        wbits = s.rx_sh << sh_amt;
        wp = s.wr_ptr;
        adc_entry = {4'h0, adc_code, 2'h0};
        temp_entry = {4'h0, temp_code};

        // ------------------------------------------------------------
        // Command reception
        // ------------------------------------------------------------
        if (s.cs_s) begin
            next_s.rx_cnt = 3'h0;
        end
        if (rise) begin
            next_s.rx_sh = byte_in;
            next_s.rx_cnt = s.rx_cnt + 3'h1;
            if (s.rx_cnt == 3'h7) begin
                if (byte_in[7]) begin
                    next_s.conv = byte_in;
                    next_s.chan = byte_in[6:3];
                    if (s.setup[5:4] == adc_link_pkg::CKM_EXT) begin
                        // Scan and averaging fields are not consulted here
                        next_s.ext_arm = 1'b1;
                        next_s.ext_temp = byte_in[0];
                        next_s.start = 1'b1;
                    end else if (!s.busy) begin
                        next_s.busy = 1'b1;
                        next_s.busy_cnt = 8'h00;
                        next_s.eoc_n = 1'b1;
                        next_s.start = 1'b1;
                    end
                end else if (byte_in[6]) begin
                    next_s.setup = byte_in;
                end else if (byte_in[5]) begin
                    next_s.avg = byte_in;
                end else if (byte_in[4]) begin
                    if (!byte_in[3]) begin
                        next_s.setup = adc_link_pkg::SETUP_RST;
                        next_s.avg = 8'h00;
                        next_s.conv = 8'h00;
                    end
                    next_s.rd_ptr = s.wr_ptr;
                    next_s.pos = 5'h00;
                    next_s.stop = adc_link_pkg::ENTRY_BITS;
                end
            end
        end

        // Cut-short write merges only the bits that arrived
        if (cs_rise && s.rx_cnt != 3'h0) begin
            if (wbits[7]) begin
                next_s.conv = (s.conv & ~wmask) | (wbits & wmask);
            end else if (s.rx_cnt >= 3'h2 && wbits[6]) begin
                next_s.setup = (s.setup & ~wmask) | (wbits & wmask);
            end else if (s.rx_cnt >= 3'h3 && wbits[5]) begin
                next_s.avg = (s.avg & ~wmask) | (wbits & wmask);
            end
        end

        // ------------------------------------------------------------
        // Serially clocked conversion output
        // ------------------------------------------------------------
        if (fall_raw) begin
            if (s.ext_arm) begin
                next_s.ext_arm = 1'b0;
                if (s.ext_temp) begin
                    next_s.ext_cnt = adc_link_pkg::TEMP_BITS;
                    next_s.ext_frame = temp_entry;
                end else begin
                    next_s.ext_cnt = adc_link_pkg::CONV_BITS;
                    next_s.ext_frame = adc_entry;
                end
            end else if (s.ext_cnt != 8'h00) begin
                next_s.ext_cnt = s.ext_cnt - 8'h01;
            end
        end

        // ------------------------------------------------------------
        // Internally timed conversion into the FIFO
        // ------------------------------------------------------------
        if (s.busy) begin
            next_s.busy_cnt = s.busy_cnt + 8'h01;
            if (s.busy_cnt == 8'(adc_link_pkg::CONV_CYC - 1)) begin
                next_s.busy = 1'b0;
                next_s.eoc_n = 1'b0;
                if (s.conv[0] && (wp - s.rd_ptr) != (AW + 1)'(DEPTH)) begin
                    next_s.mem[wp[AW-1:0]] = temp_entry;
                    wp = wp + (AW + 1)'(1);
                end
                if ((wp - s.rd_ptr) != (AW + 1)'(DEPTH)) begin
                    next_s.mem[wp[AW-1:0]] = adc_entry;
                    wp = wp + (AW + 1)'(1);
                end
                next_s.wr_ptr = wp;
            end
        end
        if (cs_fall) begin
            next_s.eoc_n = 1'b1;
            if (s.busy) begin
                // Conversion abandoned, stored results no longer trusted
                next_s.busy = 1'b0;
                next_s.rd_ptr = s.wr_ptr;
                next_s.pos = 5'h00;
                next_s.stop = adc_link_pkg::ENTRY_BITS;
            end
        end

        // ------------------------------------------------------------
        // FIFO readout with partial-read handling
        // ------------------------------------------------------------
        if (fall && !fifo_empty && s.ext_cnt == 8'h00 && !s.ext_arm) begin
            next_s.pos = s.pos + 5'h01;
            if (s.pos + 5'h01 == s.stop) begin
                next_s.rd_ptr = s.rd_ptr + (AW + 1)'(1);
                next_s.pos = 5'h00;
                next_s.stop = adc_link_pkg::ENTRY_BITS;
            end
        end
        if (cs_rise && s.pos != 5'h00) begin
            if (s.stop == adc_link_pkg::ENTRY_BITS && s.pos < adc_link_pkg::BYTE_BITS) begin
                next_s.stop = s.pos + adc_link_pkg::BYTE_BITS;
            end else if (s.stop != adc_link_pkg::ENTRY_BITS || s.pos > adc_link_pkg::BYTE_BITS) begin
                // Only this entry is dropped, later ones stay aligned
                next_s.rd_ptr = s.rd_ptr + (AW + 1)'(1);
                next_s.pos = 5'h00;
                next_s.stop = adc_link_pkg::ENTRY_BITS;
            end
        end

        if (s.ext_cnt != 8'h00) begin
            next_s.miso = 1'b0;
            if (s.ext_cnt <= adc_link_pkg::CONV_BITS) begin
                next_s.miso = s.ext_frame[4'(s.ext_cnt - 8'h01)];
            end
        end else if (!fifo_empty && !s.cs_s) begin
            next_s.miso = s.mem[s.rd_ptr[AW-1:0]][4'(5'h0F - s.pos)];
        end else begin
            next_s.miso = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.cs_m <= 1'b1;
            s.cs_s <= 1'b1;
            s.cs_d <= 1'b1;
            s.eoc_n <= 1'b1;
            s.setup <= adc_link_pkg::SETUP_RST;
            s.stop <= adc_link_pkg::ENTRY_BITS;
        end else begin
            s <= next_s;
        end
    end

    assign link.miso = s.miso;
    assign link.eoc_n = s.eoc_n;
    assign conv_start = s.start;
    assign conv_channel = s.chan;
    assign clock_mode = s.setup[5:4];
endmodule
`default_nettype wire

// ==== adc_serial_host.sv ====
// Controller end of the serial link with an AXI4-Lite register port
`default_nettype none
module adc_serial_host (
    input wire logic aclk,
    input wire logic aresetn,
    adc_link_if.host link,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);
    typedef struct packed {
        logic miso_m;
        logic miso_s;
        logic eoc_m;
        logic eoc_s;
        logic eoc_d;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdat;
        logic [3:0] wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [15:0] rx;
        logic [1:0] ist;
        logic [1:0] imask;
        adc_link_pkg::host_state_t st;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [7:0] bytes;
        logic [11:0] hold;
        logic first;
    } host_state_t;

    host_state_t s;
    host_state_t next_s;
    logic go;
    logic [1:0] ev;
    logic [1:0] w1c;
    logic [31:0] merged;
    logic [7:0] nzero;

    always_comb begin
        next_s = s;
        next_s.miso_m = link.miso;
        next_s.miso_s = s.miso_m;
        next_s.eoc_m = link.eoc_n;
        next_s.eoc_s = s.eoc_m;
        next_s.eoc_d = s.eoc_s;
        go = 1'b0;
        ev = 2'h0;
        w1c = 2'h0;
        ev[adc_link_pkg::INT_EOC] = s.eoc_d & ~s.eoc_s;
        merged = s.ctrl;
        for (int i = 0; i < 4; i++) begin
            if (s.wstb[i]) begin
                merged[i*8 +: 8] = s.wdat[i*8 +: 8];
            end
        end
        // Zero count of 0 picks the standard length, 1 allows back-to-back
        nzero = s.ctrl[15:8];
        if (nzero == 8'h00 && s.ctrl[7]) begin
            nzero = s.ctrl[0] ? adc_link_pkg::TEMP_ZERO_BYTES
                              : adc_link_pkg::CONV_ZERO_BYTES;
        end

        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        if (awvalid && !s.aw_got && !s.bvalid) begin
            next_s.aw_got = 1'b1;
            next_s.waddr = awaddr;
        end
        if (wvalid && !s.w_got && !s.bvalid) begin
            next_s.w_got = 1'b1;
            next_s.wdat = wdata;
            next_s.wstb = wstrb;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = adc_link_pkg::RESP_OKAY;
            if (s.waddr == adc_link_pkg::OFS_CTRL) begin
                next_s.ctrl = merged;
            end else if (s.waddr == adc_link_pkg::OFS_GO) begin
                go = s.wdat[0] & s.wstb[0];
            end else if (s.waddr == adc_link_pkg::OFS_INT_STATUS) begin
                w1c = s.wdat[1:0] & {2{s.wstb[0]}};
            end else if (s.waddr == adc_link_pkg::OFS_INT_MASK) begin
                next_s.imask = s.wstb[0] ? s.wdat[1:0] : s.imask;
            end else if (s.waddr != adc_link_pkg::OFS_STATUS
                         && s.waddr != adc_link_pkg::OFS_RXDATA) begin
                next_s.bresp = adc_link_pkg::RESP_SLVERR;
            end
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = adc_link_pkg::RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (araddr == adc_link_pkg::OFS_CTRL) begin
                next_s.rdata = s.ctrl;
            end else if (araddr == adc_link_pkg::OFS_STATUS) begin
                next_s.rdata = {30'h0000_0000, s.eoc_s, s.st != adc_link_pkg::H_IDLE};
            end else if (araddr == adc_link_pkg::OFS_RXDATA) begin
                next_s.rdata = {20'h0_0000, s.rx[11:0]};
            end else if (araddr == adc_link_pkg::OFS_INT_STATUS) begin
                next_s.rdata = {30'h0000_0000, s.ist};
            end else if (araddr == adc_link_pkg::OFS_INT_MASK) begin
                next_s.rdata = {30'h0000_0000, s.imask};
            end else if (araddr != adc_link_pkg::OFS_GO) begin
                next_s.rresp = adc_link_pkg::RESP_SLVERR;
            end
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // Link sequencer
        // ------------------------------------------------------------
        case (s.st)
            adc_link_pkg::H_IDLE: begin
                if (go) begin
                    next_s.bytes = nzero;
                    next_s.sh = s.ctrl[7:0];
                    next_s.mosi = s.ctrl[7];
                    next_s.first = 1'b1;
                    next_s.bitc = 3'h0;
                    next_s.div = 8'h00;
                    next_s.st = adc_link_pkg::H_SHIFT;
                    next_s.cs_n = 1'b0;
                    if (s.ctrl[adc_link_pkg::CTRL_WAIT_EOC]) begin
                        next_s.st = adc_link_pkg::H_WAIT_EOC;
                        next_s.cs_n = 1'b1;
                    end
                end
            end
            adc_link_pkg::H_WAIT_EOC: begin
                if (!s.eoc_s) begin
                    next_s.cs_n = 1'b0;
                    next_s.st = adc_link_pkg::H_SHIFT;
                end
            end
            adc_link_pkg::H_SHIFT: begin
                next_s.div = s.div + 8'h01;
                if (s.div == 8'(adc_link_pkg::SCLK_HALF - 1)) begin
                    next_s.div = 8'h00;
                    next_s.sclk = ~s.sclk;
                    if (s.sclk) begin
                        // Sampled late in the high phase to absorb the far end's sync delay
                        next_s.rx = {s.rx[14:0], s.miso_s};
                        next_s.bitc = s.bitc + 3'h1;
                        next_s.sh = {s.sh[6:0], 1'b0};
                        next_s.mosi = s.sh[6];
                        if (s.bitc == 3'h7) begin
                            next_s.first = 1'b0;
                            next_s.bytes = s.bytes - 8'h01;
                            if (s.bytes == 8'h00) begin
                                next_s.cs_n = 1'b1;
                                next_s.st = adc_link_pkg::H_IDLE;
                                ev[adc_link_pkg::INT_DONE] = 1'b1;
                            end else if (s.first && s.ctrl[adc_link_pkg::CTRL_REF_HOLD]) begin
                                // 65us wait stays inside the 100us pulse limit
                                next_s.cs_n = 1'b1;
                                next_s.hold = 12'h000;
                                next_s.st = adc_link_pkg::H_HOLD;
                            end
                        end
                    end
                end
            end
            adc_link_pkg::H_HOLD: begin
                next_s.hold = s.hold + 12'h001;
                if (s.hold == 12'(adc_link_pkg::REF_UP_CYC - 1)) begin
                    next_s.cs_n = 1'b0;
                    next_s.div = 8'h00;
                    next_s.st = adc_link_pkg::H_SHIFT;
                end
            end
            default: begin
                next_s.st = adc_link_pkg::H_IDLE;
            end
        endcase
        // Event in the clearing cycle survives
        next_s.ist = (s.ist & ~w1c) | ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.cs_n <= 1'b1;
            s.eoc_m <= 1'b1;
            s.eoc_s <= 1'b1;
            s.eoc_d <= 1'b1;
            s.st <= adc_link_pkg::H_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign link.cs_n = s.cs_n;
    assign link.sclk = s.sclk;
    assign link.mosi = s.mosi;
    assign awready = !s.aw_got && !s.bvalid;
    assign wready = !s.w_got && !s.bvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = !s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign irq = |(s.ist & s.imask);
endmodule
`default_nettype wire

// ==== adc_link_monitor.sv ====
// Protocol checker for the serial converter link
`default_nettype none
module adc_link_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic eoc_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk_d;
    logic [7:0] bits;
    logic [3:0] idle;
    // Bit count per select session; a select pulse restarts it
    always_ff @(posedge aclk) begin
        sclk_d <= sclk;
        if (!aresetn || !cs_n) idle <= 4'h0;
        else if (idle != 4'hF) idle <= idle + 4'h1;
        if (!aresetn || cs_n) bits <= 8'h00;
        else if (sclk && !sclk_d) bits <= bits + 8'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sclk_idle_low_a: assert property (cs_n |-> !sclk) else $error("sclk runs outside select");
    mosi_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    sclk_half_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high phase not four cycles");
    // Sixteen clocks is a plain FIFO read session
    frame_len_a: assert property ($rose(cs_n) |->
        bits inside {8'h08, 8'h10, 8'h18, 8'hC0, 8'hC8}) else $error("select session length wrong");
    zero_fill_a: assert property (sclk && !sclk_d && bits >= 8'h08 |-> !mosi)
        else $error("nonzero fill after command byte");
    miso_idle_a: assert property (idle == 4'hF |-> !miso) else $error("miso busy while idle");
    eoc_release_a: assert property ($fell(cs_n) |-> ##[0:8] eoc_n)
        else $error("eoc_n stays low under select");
    reset_idle_a: assert property ($rose(aresetn) |->
        cs_n && !sclk && eoc_n && !miso) else $error("link not idle after reset");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Bench driving the controller over AXI4-Lite against the converter end
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid, irq;
    logic conv_start;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0] bresp, rresp, rsp, clock_mode;
    logic [3:0] conv_channel;
    logic [9:0] adc_code = 10'h0;
    logic [11:0] temp_code = 12'h0;
    int fail_count = 0, checked = 0, starts = 0;
    adc_link_if u_adc_link_if ();
    adc_serial_device u_adc_serial_device (.aclk, .aresetn, .link(u_adc_link_if), .adc_code,
        .temp_code, .conv_start, .conv_channel, .clock_mode);
    adc_serial_host u_adc_serial_host (.aclk, .aresetn, .link(u_adc_link_if), .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
    adc_link_monitor u_adc_link_monitor (.aclk, .aresetn, .cs_n(u_adc_link_if.cs_n),
        .sclk(u_adc_link_if.sclk), .mosi(u_adc_link_if.mosi), .miso(u_adc_link_if.miso),
        .eoc_n(u_adc_link_if.eoc_n));
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) if (conv_start === 1'h1) starts++;
    // ------------------------------------------------------------
    // Bus access and checking
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Takes are judged at the falling edge so the rising edge never races
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        logic done, ta, tw;
        done = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= we;
        wvalid <= we;
        bready <= we;
        arvalid <= !we;
        rready <= !we;
        for (int n = 0; n < 60 && !done; n++) begin
            @(negedge aclk);
            ta = (awvalid && awready === 1'h1) || (arvalid && arready === 1'h1);
            tw = wvalid && wready === 1'h1;
            done = we ? bvalid === 1'h1 : rvalid === 1'h1;
            rd = rdata;
            rsp = we ? bresp : rresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (ta) arvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        rready <= 1'h0;
        if (!done) chk("bus wait", 32'h1, 32'h0);
        if (!done) complete_run();
    endtask
    task automatic run(input logic [31:0] ctrl);
        bus(1'h1, adc_link_pkg::OFS_CTRL, ctrl);
        bus(1'h1, adc_link_pkg::OFS_GO, 32'h1);
        rd = 32'h1;
        for (int n = 0; n < 2000 && rd[0]; n++) bus(1'h0, adc_link_pkg::OFS_STATUS, 32'h0);
        if (rd[0] !== 1'h0) chk("sequence wait", 32'h0, rd);
        if (rd[0] !== 1'h0) complete_run();
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        bus(1'h1, adc_link_pkg::OFS_INT_MASK, 32'h1);
        run(32'h70);
        chk("clock_mode", 32'h3, clock_mode);
        chk("irq raised", 32'h1, irq);
        bus(1'h1, adc_link_pkg::OFS_INT_STATUS, 32'h1);
        chk("irq cleared", 32'h0, irq);
        bus(1'h1, adc_link_pkg::OFS_INT_MASK, 32'h0);
        for (int i = 0; i < 2; i++) begin
            adc_code <= i ? 10'h3FF : 10'h155;
            run({24'h0, 1'h1, i ? 4'hF : 4'h5, 3'h0});
            chk("conv_channel", i ? 32'hF : 32'h5, conv_channel);
            bus(1'h0, adc_link_pkg::OFS_RXDATA, 32'h0);
            chk("adc result", {20'h0, adc_code, 2'h0}, rd);
        end
        chk("irq masked", 32'h0, irq);
        temp_code <= 12'hABC;
        // Select held high for reference power-up before the zero bytes
        run(32'h0002_0081);
        bus(1'h0, adc_link_pkg::OFS_RXDATA, 32'h0);
        chk("temp result", 32'h0000_0ABC, rd);
        chk("conv starts", 32'h3, starts);
        bus(1'h1, adc_link_pkg::OFS_INT_MASK, 32'h1);
        chk("irq unmasked", 32'h1, irq);
        bus(1'h0, 8'h40, 32'h0);
        chk("unmapped read", 32'h2, {30'h0, rsp});
        bus(1'h1, 8'h40, 32'h0);
        chk("unmapped write", 32'h2, {30'h0, rsp});
        // Internal mode: temp entry is cut after 14 bits, the conversion entry survives
        adc_code <= 10'h0C3;
        run(32'h60);
        chk("clock_mode internal", 32'h2, clock_mode);
        run(32'h0000_0281);
        bus(1'h0, adc_link_pkg::OFS_STATUS, 32'h0);
        chk("eoc low", 32'h0, rd);
        bus(1'h0, adc_link_pkg::OFS_INT_STATUS, 32'h0);
        chk("eoc event", 32'h3, rd);
        run(32'h0001_0100);
        bus(1'h0, adc_link_pkg::OFS_RXDATA, 32'h0);
        chk("fifo entry", 32'h0000_030C, rd);
        complete_run();
    end
endmodule
`default_nettype wire
